// File: dv/dcl_top_bench.sv
`timescale 1ns/1ps
module dcl_top_bench;
   // ---------------------------------------------------------------
   // Stimulus, observation and bookkeeping
   // ---------------------------------------------------------------
   logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, clk_per_avail_i;
   logic debug_halt_i;
   logic [5:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rdat;
   logic [1:0] sleep_mode_i;
   logic wb_ack_o, wb_err_o, conv_start_o, conv_power_o, buf_power_o;
   logic pin_route_o, internal_valid_o, berr, bst;
   logic [7:0] conv_code_o;
   logic np_buf, np_pin, np_int; // Instance without a pin driver
   int n_mismatch = 0;
   int check_count = 0;
   int n;
   dcl_top #(.HAS_PIN(1'b1)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .wb_err_o(wb_err_o), .sleep_mode_i(sleep_mode_i),
      .clk_per_avail_i(clk_per_avail_i), .debug_halt_i(debug_halt_i),
      .conv_code_o(conv_code_o), .conv_start_o(conv_start_o),
      .conv_power_o(conv_power_o), .buf_power_o(buf_power_o),
      .pin_route_o(pin_route_o), .internal_valid_o(internal_valid_o));
   // Second instance shares all inputs; only its analog flags are watched
   dcl_top #(.HAS_PIN(1'b0)) i_dut_np (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(), .wb_err_o(),
      .sleep_mode_i(sleep_mode_i), .clk_per_avail_i(clk_per_avail_i),
      .debug_halt_i(debug_halt_i), .conv_code_o(), .conv_start_o(),
      .conv_power_o(), .buf_power_o(np_buf), .pin_route_o(np_pin),
      .internal_valid_o(np_int));
   // Free-running 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic end_of_test;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One classic cycle; ack and err are registered, so hold until seen
   task automatic bus(input logic we, input logic [5:0] adr,
                      input logic [7:0] wd);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h000000, wd};
      do begin
         @(posedge clk_i);
         k++;
      end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && k < 20);
      if (k >= 20) begin
         n_mismatch++;
         end_of_test();
      end
      rdat = wb_dat_o;
      berr = wb_err_o;
      bst = conv_start_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   // Count edges until the start pulse; a missing pulse ends the run
   task automatic wait_start;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (conv_start_o !== 1'b1 && n < 300);
      if (n >= 300) begin
         n_mismatch++;
         end_of_test();
      end
      chk("startup", 32'(n >= dcl_pkg::STARTUP_CYC &&
          n <= dcl_pkg::STARTUP_CYC + 8), 32'h1);
   endtask : wait_start
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_map;
      bus(1'b0, dcl_pkg::CTRL_ADDR, 8'h00);
      chk("ctrl rst", rdat, 32'h0);
      bus(1'b0, dcl_pkg::CODE_ADDR, 8'h00);
      chk("code rst", rdat, 32'h0);
      bus(1'b1, 6'h08, 8'hFF);
      chk("unmapped err", 32'(berr), 32'h1);
   endtask : t_reset_map
   task automatic t_store_then_enable;
      bus(1'b1, dcl_pkg::CODE_ADDR, 8'h5A);
      chk("no start off", 32'(bst), 32'h0);
      chk("power off", 32'(conv_power_o), 32'h0);
      bus(1'b1, dcl_pkg::CTRL_ADDR, 8'hFF);
      wait_start();
      chk("code", 32'(conv_code_o), 32'h5A);
      bus(1'b0, dcl_pkg::CTRL_ADDR, 8'h00);
      chk("ctrl rsvd", rdat, 32'hC1);
      @(posedge clk_i);
      chk("buf", 32'(buf_power_o), 32'h1);
      chk("pin", 32'(pin_route_o), 32'h1);
      chk("np pin", 32'({np_buf, np_pin, np_int}), 32'h1);
      bus(1'b1, dcl_pkg::CTRL_ADDR, 8'h81);
      repeat (3) @(posedge clk_i);
      chk("buf off", 32'({buf_power_o, pin_route_o}), 32'h0);
      chk("internal", 32'(internal_valid_o), 32'h1);
   endtask : t_store_then_enable
   task automatic t_write_enabled;
      debug_halt_i <= 1'b1;
      ce_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("frozen", 32'(conv_power_o), 32'h1);
      ce_i <= 1'b1;
      bus(1'b1, dcl_pkg::CODE_ADDR, 8'hA5);
      chk("start on write", 32'(bst), 32'h1);
      chk("new code", 32'(conv_code_o), 32'hA5);
      debug_halt_i <= 1'b0;
   endtask : t_write_enabled
   task automatic t_sleep;
      sleep_mode_i <= dcl_pkg::DCL_STANDBY;
      repeat (5) @(posedge clk_i);
      chk("stby run", 32'(conv_power_o), 32'h1);
      clk_per_avail_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk("stby stop", 32'(conv_power_o), 32'h0);
      clk_per_avail_i <= 1'b1;
      sleep_mode_i <= dcl_pkg::DCL_ACTIVE;
      wait_start();
      bus(1'b1, dcl_pkg::CTRL_ADDR, 8'hC1);
      sleep_mode_i <= dcl_pkg::DCL_PDOWN;
      repeat (5) @(posedge clk_i);
      chk("pdown", 32'({conv_power_o, buf_power_o}), 32'h0);
      sleep_mode_i <= dcl_pkg::DCL_ACTIVE;
      wait_start();
   endtask : t_sleep
   task automatic t_disable;
      bus(1'b1, dcl_pkg::CTRL_ADDR, 8'h00);
      repeat (3) @(posedge clk_i);
      chk("disabled", 32'({conv_power_o, internal_valid_o}), 32'h0);
      bus(1'b1, dcl_pkg::CODE_ADDR, 8'h33);
      chk("no start", 32'(bst), 32'h0);
      wb_sel_i <= 4'h0;
      bus(1'b1, dcl_pkg::CODE_ADDR, 8'h77);
      wb_sel_i <= 4'hF;
      bus(1'b0, dcl_pkg::CODE_ADDR, 8'h00);
      chk("sel ignored", rdat, 32'h33);
   endtask : t_disable
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 6'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      sleep_mode_i = dcl_pkg::DCL_ACTIVE;
      clk_per_avail_i = 1'b1;
      debug_halt_i = 1'b0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset_map();
      t_store_then_enable();
      t_write_enabled();
      t_sleep();
      t_disable();
      end_of_test();
   end
endmodule : dcl_top_bench

// File: hdl/dcl_pkg.sv
package dcl_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0] CTRL_IDX = 4'h0; // Control register index
   localparam logic [3:0] CODE_IDX = 4'h1; // Sample register index
   localparam logic [5:0] CTRL_ADDR = 6'h00; // Byte address, index * 4
   localparam logic [5:0] CODE_ADDR = 6'h04; // Byte address, index * 4
   localparam int EN_BIT = 0;   // Converter enable
   localparam int PIN_BIT = 6;  // Pin output enable
   localparam int STBY_BIT = 7; // Run in standby
   localparam logic [7:0] CTRL_MASK = 8'hC1; // Implemented control bits
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CODE_RST = 8'h00;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int STARTUP_NS = 1000; // Analog start-up time
   localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 8;
   // ---------------------------------------------------------------
   // Sleep modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      DCL_ACTIVE = 2'h0,
      DCL_IDLE = 2'h1,
      DCL_STANDBY = 2'h2,
      DCL_PDOWN = 2'h3
   } dcl_sleep_t;
   // Power state machine, Gray along off, start, run
   typedef enum logic [1:0] {
      DCL_OFF = 2'h0,
      DCL_START = 2'h1,
      DCL_RUN = 2'h3
   } dcl_pwr_t;
endpackage : dcl_pkg

// File: hdl/dcl_pwr_if.sv
`timescale 1ns/1ps
// Power request and status between the top and the power sequencer
interface dcl_pwr_if;
   logic want_on;  // Converter should be powered
   logic ready;    // Start-up time has passed
   logic powered;  // Analog core is powered
   modport ctl (output want_on, input ready, input powered);
   modport seq (input want_on, output ready, output powered);
endinterface : dcl_pwr_if

// File: hdl/dcl_pwr_seq.sv
`timescale 1ns/1ps
// Power sequencer: counts the start-up time after power is applied
module dcl_pwr_seq (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   dcl_pwr_if.seq pwr
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   dcl_pkg::dcl_pwr_t state_r; // Power state
   logic [dcl_pkg::CNT_W-1:0] cnt_r; // Start-up counter

   // Sequencing; dropping the request always powers down at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= dcl_pkg::DCL_OFF;
         cnt_r <= '0;
      end else if (ce_i) begin
         case (state_r)
            dcl_pkg::DCL_OFF: begin
               cnt_r <= '0;
               if (pwr.want_on) begin
                  state_r <= dcl_pkg::DCL_START;
               end
            end
            dcl_pkg::DCL_START: begin
               // Wait out the start-up time before converting
               if (!pwr.want_on) begin
                  state_r <= dcl_pkg::DCL_OFF;
               end else if (cnt_r ==
                  dcl_pkg::CNT_W'(dcl_pkg::STARTUP_CYC - 1)) begin
                  state_r <= dcl_pkg::DCL_RUN;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            dcl_pkg::DCL_RUN: begin
               if (!pwr.want_on) begin
                  state_r <= dcl_pkg::DCL_OFF;
               end
            end
            default: begin
               state_r <= dcl_pkg::DCL_OFF;
            end
         endcase
      end
   end

   assign pwr.powered = (state_r != dcl_pkg::DCL_OFF);
   assign pwr.ready = (state_r == dcl_pkg::DCL_RUN);
endmodule : dcl_pwr_seq

// File: hdl/dcl_top.sv
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module dcl_top #(
   parameter bit HAS_PIN = 1'b1 // Set only for instance zero
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // System state
   input wire logic [1:0] sleep_mode_i, // Sleep mode, same clock
   input wire logic clk_per_avail_i,    // Peripheral clock kept in sleep
   input wire logic debug_halt_i,       // CPU halted by the debugger
   // Analog side
   output logic [7:0] conv_code_o,   // Code held by the converter
   output logic conv_start_o,        // One-cycle conversion start
   output logic conv_power_o,        // Converter core powered
   output logic buf_power_o,         // Output buffer powered
   output logic pin_route_o,         // Result routed to pin
   output logic internal_valid_o     // Result offered to AC and ADC
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] ctrl_r;  // Control register, implemented bits only
   logic [7:0] code_r;  // Sample register
   logic ack_r;         // Bus acknowledge
   logic err_r;         // Bus error for unmapped address
   logic [31:0] rdat_r; // Read data
   logic pend_r;        // Conversion owed once converter is ready
   logic start_r;       // Conversion start pulse
   logic [7:0] conv_r;  // Code latched into the converter
   logic cpow_r;        // Converter power output
   logic bpow_r;        // Buffer power output
   logic pin_r;         // Pin route output
   logic ival_r;        // Internal valid output
   dcl_pwr_if pwr ();   // Power sequencer link

   // Decode
   logic req;
   logic hit_ctrl;
   logic hit_code;
   logic wr_ctrl;
   logic wr_code;
   logic en_rise;
   logic sleep_off;
   logic [7:0] ctrl_nxt;
   assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
   assign hit_ctrl = (wb_adr_i == dcl_pkg::CTRL_ADDR);
   assign hit_code = (wb_adr_i == dcl_pkg::CODE_ADDR);
   assign wr_ctrl = req && wb_we_i && hit_ctrl && wb_sel_i[0];
   assign wr_code = req && wb_we_i && hit_code && wb_sel_i[0];
   assign ctrl_nxt = wb_dat_i[7:0] & dcl_pkg::CTRL_MASK;
   assign en_rise = wr_ctrl && ctrl_nxt[dcl_pkg::EN_BIT]
      && !ctrl_r[dcl_pkg::EN_BIT];

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   // One-cycle answer; ack and err drop the cycle after they rise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         err_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_r <= req && (hit_ctrl || hit_code);
         err_r <= req && !(hit_ctrl || hit_code);
         if (req && !wb_we_i) begin
            // Only the low byte lane carries data; the rest read zero
            if (hit_ctrl) begin
               rdat_r <= {24'h00_0000, ctrl_r};
            end else if (hit_code) begin
               rdat_r <= {24'h00_0000, code_r};
            end else begin
               rdat_r <= 32'h0000_0000;
            end
         end
      end
   end

   // Control register; reserved bits never stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= dcl_pkg::CTRL_RST;
      end else if (ce_i && wr_ctrl) begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Sample register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         code_r <= dcl_pkg::CODE_RST;
      end else if (ce_i && wr_code) begin
         code_r <= wb_dat_i[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Power control
   // ---------------------------------------------------------------
   // Debug halt is deliberately ignored here
   logic [1:0] unused_dbg;
   assign unused_dbg = {debug_halt_i, 1'b0};
   // Sleep states in which the analog core must be off
   always_comb begin
      case (dcl_pkg::dcl_sleep_t'(sleep_mode_i))
         dcl_pkg::DCL_PDOWN: sleep_off = 1'b1;
         dcl_pkg::DCL_STANDBY: sleep_off =
            !(ctrl_r[dcl_pkg::STBY_BIT] && clk_per_avail_i);
         default: sleep_off = 1'b0;
      endcase
   end
   assign pwr.want_on = ctrl_r[dcl_pkg::EN_BIT] && !sleep_off;

   dcl_pwr_seq u_seq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pwr(pwr)
   );

   // ---------------------------------------------------------------
   // Conversion start
   // ---------------------------------------------------------------
   // A start owed from enabling or from waking waits for start-up time,
   // so a write landing during start-up is not lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_r <= 1'b0;
         start_r <= 1'b0;
         conv_r <= 8'h00;
      end else if (ce_i) begin
         start_r <= 1'b0;
         if (pwr.ready && (pend_r || wr_code)) begin
            // write while running converts at once
            start_r <= 1'b1;
            conv_r <= wr_code ? wb_dat_i[7:0] : code_r;
            pend_r <= 1'b0;
         end else if (en_rise) begin
            pend_r <= 1'b1;
         end else if (!pwr.powered && ctrl_r[dcl_pkg::EN_BIT]) begin
            pend_r <= 1'b1; // reconvert after wake
         end else if (!ctrl_r[dcl_pkg::EN_BIT]) begin
            pend_r <= 1'b0;
         end
      end
   end

   // Registered analog controls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpow_r <= 1'b0;
         bpow_r <= 1'b0;
         pin_r <= 1'b0;
         ival_r <= 1'b0;
      end else if (ce_i) begin
         cpow_r <= pwr.powered;
         bpow_r <= HAS_PIN && pwr.powered
            && ctrl_r[dcl_pkg::PIN_BIT];
         pin_r <= HAS_PIN && pwr.ready && ctrl_r[dcl_pkg::PIN_BIT];
         ival_r <= pwr.ready;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;
   assign wb_dat_o = rdat_r;
   assign conv_code_o = conv_r;
   assign conv_start_o = start_r;
   assign conv_power_o = cpow_r;
   assign buf_power_o = bpow_r;
   assign pin_route_o = pin_r;
   assign internal_valid_o = ival_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ctrl_reserved_a: assert property (ctrl_r[5:1] == 5'h00)
      else $error("reserved control bits set");
   pin_only_zero_a: assert property (!HAS_PIN |-> !pin_r && !bpow_r)
      else $error("pin driven on internal instance");
   pdown_off_a: assert property (
      ce_i && sleep_mode_i == 2'h3 |-> ##2 (!cpow_r && !bpow_r))
      else $error("converter on in power down");
   start_needs_en_a: assert property (
      start_r |-> $past(ctrl_r[dcl_pkg::EN_BIT]))
      else $error("start while disabled");
   write_starts_a: assert property (
      ce_i && wr_code && pwr.ready |=> start_r
      && conv_r == $past(wb_dat_i[7:0]))
      else $error("write while running did not convert");
   no_start_off_a: assert property (
      !ctrl_r[dcl_pkg::EN_BIT] |=> !start_r)
      else $error("start while disabled");
   pin_needs_bit_a: assert property (
      pin_r |-> $past(ctrl_r[dcl_pkg::PIN_BIT]))
      else $error("pin route without enable bit");
   internal_en_a: assert property (
      ival_r |-> $past(ctrl_r[dcl_pkg::EN_BIT], 2))
      else $error("internal result without enable");
   wake_startup_a: assert property (
      ce_i && !pwr.powered |=> !pwr.ready)
      else $error("no start-up time after wake");
   ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   enable_cv: cover property (en_rise ##[1:200] start_r);
   standby_cv: cover property (sleep_mode_i == 2'h2 && cpow_r);
   write_cv: cover property (wr_code && pwr.ready);
endmodule : dcl_top
